// [design/ecb_regs.vh]
// register addresses, select-register fields and reset values of the event counter bank
`ifndef ECB_REGS_VH
`define ECB_REGS_VH

// model-specific register address blocks
`define ECB_CTR_BASE 32'h000000C1
`define ECB_SEL_BASE 32'h00000186

// event_select field positions
`define ECB_EVT_LSB 0
`define ECB_QUAL_LSB 8
`define ECB_USER_BIT 16
`define ECB_SUPV_BIT 17
`define ECB_EDGE_BIT 18
`define ECB_PIN_BIT 19
`define ECB_INT_BIT 20
`define ECB_EN_BIT 22
`define ECB_INVERT_BIT 23
`define ECB_THR_LSB 24

// writable bits of event_select; bit 21 and bits 63:32 stay zero
`define ECB_SEL_WMASK 32'hFFDFFFFF
`define ECB_SEL_RESET 32'h00000000

// capability_leaf layout
`define ECB_CAP_VER_LSB 0
`define ECB_CAP_NUM_LSB 8
`define ECB_CAP_WID_LSB 16
`define ECB_CAP_NEV_LSB 24
`define ECB_VERSION 8'h01

`endif

// [design/ecb_event_filter.v]
// qualification of one counter's event: unit select, privilege, threshold, invert, edge
`timescale 1ns/1ps
`default_nettype none
`include "ecb_regs.vh"

module ecb_event_filter #(
  parameter NUM_EV = 7,
  parameter CW = 4,
  parameter [NUM_EV-1:0] EV_SUPPORT = 7'h7F,
  parameter [NUM_EV*8-1:0] EV_CODES = 56'h07060504030201,
  parameter [NUM_EV*8-1:0] EV_QUALS = 56'h00000000000000
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // configuration and events
  input wire [31:0] sel,
  input wire [NUM_EV*CW-1:0] ev_count,
  input wire [1:0] cpl,
  // increment for this cycle
  output reg [CW-1:0] inc
);

  reg prev_cond;
  reg [CW-1:0] raw;
  reg [CW-1:0] amt;
  reg priv_ok;
  reg cmp;
  integer i;

  always @* begin
    raw = {CW{1'b0}};
    amt = {CW{1'b0}};
    cmp = 1'b0;
    for (i = 0; i < NUM_EV; i = i + 1) begin
      // an unadvertised unit never matches, so its code is simply not honoured
      if (EV_SUPPORT[i] && sel[`ECB_EVT_LSB +: 8] == EV_CODES[i*8 +: 8] &&
          sel[`ECB_QUAL_LSB +: 8] == EV_QUALS[i*8 +: 8]) begin
        raw = ev_count[i*CW +: CW];
      end
    end
    priv_ok = (sel[`ECB_USER_BIT] && cpl != 2'b00) || (sel[`ECB_SUPV_BIT] && cpl == 2'b00);
    if (sel[`ECB_THR_LSB +: 8] != 8'h00) begin
      cmp = ({{(32-CW){1'b0}}, raw} >= {24'h000000, sel[`ECB_THR_LSB +: 8]}) ^ sel[`ECB_INVERT_BIT];
      amt = {{(CW-1){1'b0}}, cmp};
    end else begin
      amt = raw;
    end
    if (!priv_ok) begin
      amt = {CW{1'b0}};
    end
    if (sel[`ECB_EDGE_BIT]) begin
      amt = {{(CW-1){1'b0}}, (amt != {CW{1'b0}}) && !prev_cond};
    end
    inc = sel[`ECB_EN_BIT] ? amt : {CW{1'b0}};
  end

  // edge history follows the qualified condition, forgotten while disabled
  always @(posedge clk) begin
    if (rst || !sel[`ECB_EN_BIT]) begin
      prev_cond <= 1'b0;
    end else begin
      prev_cond <= priv_ok && ((sel[`ECB_THR_LSB +: 8] != 8'h00) ? cmp : (raw != {CW{1'b0}}));
    end
  end

endmodule // ecb_event_filter
`default_nettype wire

// [design/ecb_pin_pulse.v]
// monitor output pin pulse: high for one bus clock, given in core cycles
`timescale 1ns/1ps
`default_nettype none

module ecb_pin_pulse #(
  parameter BUS_RATIO = 4
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // toggle request and pin
  input wire fire,
  output reg pin
);

  reg [7:0] left;

  // a new request during a pulse restarts it; pulses cannot queue
  always @(posedge clk) begin
    if (rst) begin
      pin <= 1'b0;
      left <= 8'h00;
    end else if (fire) begin
      pin <= 1'b1;
      left <= BUS_RATIO[7:0] - 8'h01;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end else begin
      pin <= 1'b0;
    end
  end

endmodule // ecb_pin_pulse
`default_nettype wire

// [design/ecb_top.v]
// event counter bank: per-thread counters, event selects, capability leaf, pins and interrupts
// Function
// - Counters sit contiguously from the counter base; count reported in capability bits 15:8.
// - Select registers sit contiguously from the select base, paired by index.
// - Width reported in bits 23:16; bits above width ignored on write.
// - Counter writes update only the low 32 bits (the code clears the bits above them); reads return full width.
// - Every logical processor has private selects and counters.
// - Nonzero version identifier in capability bits 7:0 shows the facility exists.
// - Select bits 7:0 choose the event unit feeding the counter.
// - Select bits 15:8 qualify the condition of the chosen unit.
// - A capability vector advertises which predefined events are supported.
// - User flag bit 16 counts at privilege levels one to three.
// - Supervisor flag bit 17 counts at privilege level zero.
// - Edge flag bit 18 counts false-to-true transitions only.
// - Pin flag bit 19: toggle pin per event, else only on overflow.
// - A pin toggle is one bus clock high, then low.
// - Interrupt flag bit 20 raises an interrupt request on overflow.
// - Counting happens only while enable bit 22 is set.
// - Invert flag bit 23 inverts the threshold comparison.
// - Nonzero threshold: add one when per-cycle count reaches the threshold.
// - Zero threshold: add the full per-cycle event count.
`timescale 1ns/1ps
`default_nettype none
`include "ecb_regs.vh"

module ecb_top #(
  parameter NUM_LP = 2,
  parameter NUM_CTR = 2,
  parameter CTR_W = 40,
  parameter NUM_EV = 7,
  parameter CW = 4,
  parameter BUS_RATIO = 4,
  parameter [NUM_EV-1:0] EV_SUPPORT = 7'h7F,
  parameter [NUM_EV*8-1:0] EV_CODES = 56'h07060504030201,
  parameter [NUM_EV*8-1:0] EV_QUALS = 56'h00000000000000
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // model-specific register access
  input wire msr_req,
  input wire msr_wr,
  input wire [7:0] msr_lp,
  input wire [31:0] msr_addr,
  input wire [63:0] msr_wdata,
  output reg msr_ack,
  output reg msr_fault,
  output reg [63:0] msr_rdata,
  // capability_leaf
  output reg [31:0] cap_eax,
  output reg [31:0] cap_ebx,
  // events and privilege per logical processor
  input wire [NUM_LP*NUM_EV*CW-1:0] ev_count,
  input wire [NUM_LP*2-1:0] cpl,
  // monitor_output_pin per counter, interrupt request per logical processor
  output wire [NUM_LP*NUM_CTR-1:0] monitor_output_pin,
  output reg [NUM_LP-1:0] irq_req
);

  localparam TOT = NUM_LP * NUM_CTR;
  localparam [7:0] NUM_CTR8 = NUM_CTR;
  localparam [7:0] CTR_W8 = CTR_W;
  localparam [7:0] NUM_EV8 = NUM_EV;
  localparam [31:0] NUM_CTR32 = NUM_CTR;

  // capability words, fixed by the parameters
  localparam [31:0] CAP_EAX = {NUM_EV8, CTR_W8, NUM_CTR8, `ECB_VERSION};
  localparam [31:0] CAP_EBX = {{(32-NUM_EV){1'b0}}, EV_SUPPORT};

  // private per-thread state, flat index lp*NUM_CTR + counter
  reg [31:0] event_select [0:TOT-1];
  reg [CTR_W-1:0] event_counter [0:TOT-1];

  wire [TOT*CW-1:0] inc_all;
  wire [TOT-1:0] ovf;
  wire [TOT-1:0] pin_fire;
  wire [TOT*CTR_W-1:0] sum_all;
  // per-counter copies of the pin and interrupt flags
  wire [TOT-1:0] pin_ev;
  wire [TOT-1:0] int_en;

  // decode results
  reg hit_ctr;
  reg hit_sel;
  reg lp_ok;
  reg [31:0] slot;
  reg [31:0] flat;

  integer k;
  integer l;
  reg [NUM_LP-1:0] next_irq;
  // strobe and read-data decode
  integer m;
  integer n;
  reg [TOT-1:0] wr_ctr;
  reg [TOT-1:0] wr_sel;
  reg [63:0] next_rdata;

  // counter write value: low 32 bits only, upper implemented bits clear
  function [CTR_W-1:0] to_ctr;
    input [63:0] wdata;
    reg [63:0] t;
    begin
      t = {32'h00000000, wdata[31:0]};
      to_ctr = t[CTR_W-1:0];
    end
  endfunction

  // read value: bits above the implemented width read as zero
  function [63:0] from_ctr;
    input [CTR_W-1:0] v;
    reg [63:0] t;
    begin
      t = 64'h0000000000000000;
      t[CTR_W-1:0] = v;
      from_ctr = t;
    end
  endfunction

  // address falls inside a block of NUM_CTR registers from base
  function in_block;
    input [31:0] addr;
    input [31:0] base;
    begin
      in_block = (addr >= base) && (addr < base + NUM_CTR32);
    end
  endfunction

  // logical processor that owns a flat counter index
  function integer lp_of;
    input integer idx;
    begin
      lp_of = idx / NUM_CTR;
    end
  endfunction

  // address decode into the two contiguous blocks
  always @* begin
    hit_ctr = 1'b0;
    hit_sel = 1'b0;
    slot = 32'h00000000;
    // the thread bound keeps a refused access from landing in another thread's slot
    lp_ok = ({24'h000000, msr_lp} < NUM_LP);
    if (in_block(msr_addr, `ECB_CTR_BASE)) begin
      hit_ctr = lp_ok;
      slot = msr_addr - `ECB_CTR_BASE;
    end else if (in_block(msr_addr, `ECB_SEL_BASE)) begin
      hit_sel = lp_ok;
      slot = msr_addr - `ECB_SEL_BASE;
    end
    flat = {24'h000000, msr_lp} * NUM_CTR32 + slot;
  end

  // write strobes per slot, decoded once for both register blocks
  // a refused access strobes nothing
  always @* begin
    wr_ctr = {TOT{1'b0}};
    wr_sel = {TOT{1'b0}};
    for (m = 0; m < TOT; m = m + 1) begin
      if (msr_req && msr_wr && hit_ctr && flat == m) begin
        wr_ctr[m] = 1'b1;
      end
      if (msr_req && msr_wr && hit_sel && flat == m) begin
        wr_sel[m] = 1'b1;
      end
    end
  end

  genvar g;
  generate
    // one event filter and one pin pulser per counter
    for (g = 0; g < TOT; g = g + 1) begin : g_ctr
      wire [CTR_W:0] sum;
      wire [CW-1:0] inc;

      ecb_event_filter #(
        .NUM_EV(NUM_EV),
        .CW(CW),
        .EV_SUPPORT(EV_SUPPORT),
        .EV_CODES(EV_CODES),
        .EV_QUALS(EV_QUALS)
      ) u_filter (
        .clk(clk),
        .rst(rst),
        .sel(event_select[g]),
        .ev_count(ev_count[lp_of(g) * NUM_EV * CW +: NUM_EV * CW]),
        .cpl(cpl[lp_of(g) * 2 +: 2]),
        .inc(inc_all[g*CW +: CW])
      );

      assign inc = inc_all[g*CW +: CW];
      assign sum = {1'b0, event_counter[g]} + {{(CTR_W+1-CW){1'b0}}, inc};
      assign sum_all[g*CTR_W +: CTR_W] = sum[CTR_W-1:0];
      assign ovf[g] = sum[CTR_W];
      assign pin_ev[g] = event_select[g][`ECB_PIN_BIT];
      assign int_en[g] = event_select[g][`ECB_INT_BIT];

      // per-event toggle while counting, otherwise only on overflow
      assign pin_fire[g] = pin_ev[g] ? (inc != {CW{1'b0}}) : ovf[g];

      ecb_pin_pulse #(
        .BUS_RATIO(BUS_RATIO)
      ) u_pin (
        .clk(clk),
        .rst(rst),
        .fire(pin_fire[g]),
        .pin(monitor_output_pin[g])
      );
    end
  endgenerate

  // select registers
  // bit 21 and the upper half are not kept, so they read back as zero
  always @(posedge clk) begin
    if (rst) begin
      for (n = 0; n < TOT; n = n + 1) begin
        event_select[n] <= `ECB_SEL_RESET;
      end
    end else begin
      for (n = 0; n < TOT; n = n + 1) begin
        if (wr_sel[n]) begin
          event_select[n] <= msr_wdata[31:0] & `ECB_SEL_WMASK;
        end
      end
    end
  end

  // counters: a software write wins over a same-cycle increment; software is
  // expected to disable counting before it loads a counter
  always @(posedge clk) begin
    if (rst) begin
      for (k = 0; k < TOT; k = k + 1) begin
        event_counter[k] <= {CTR_W{1'b0}};
      end
    end else begin
      for (k = 0; k < TOT; k = k + 1) begin
        if (wr_ctr[k]) begin
          event_counter[k] <= to_ctr(msr_wdata);
        end else begin
          event_counter[k] <= sum_all[k*CTR_W +: CTR_W];
        end
      end
    end
  end

  // read data is picked in the request cycle and held until the next request
  always @* begin
    next_rdata = msr_rdata;
    if (msr_req && !msr_wr && hit_ctr) begin
      next_rdata = from_ctr(event_counter[flat]);
    end else if (msr_req && !msr_wr && hit_sel) begin
      next_rdata = {32'h00000000, event_select[flat]};
    end else if (msr_req) begin
      next_rdata = 64'h0000000000000000;
    end
  end

  // register answer, one cycle after the request
  always @(posedge clk) begin
    if (rst) begin
      msr_ack <= 1'b0;
      msr_fault <= 1'b0;
      msr_rdata <= 64'h0000000000000000;
    end else begin
      msr_ack <= msr_req;
      msr_fault <= msr_req && !hit_ctr && !hit_sel;
      msr_rdata <= next_rdata;
    end
  end

  // overflow interrupt request, one pulse per overflowing cycle per thread
  always @* begin
    next_irq = {NUM_LP{1'b0}};
    for (l = 0; l < TOT; l = l + 1) begin
      if (ovf[l] && int_en[l]) begin
        next_irq[lp_of(l)] = 1'b1;
      end
    end
  end

  // registered so the request leaves the block straight from a flip-flop
  always @(posedge clk) begin
    if (rst) begin
      irq_req <= {NUM_LP{1'b0}};
    end else begin
      irq_req <= next_irq;
    end
  end

  // capability leaf; constant after reset
  // held at zero in reset so software sees no facility until release
  always @(posedge clk) begin
    if (rst) begin
      cap_eax <= 32'h00000000;
      cap_ebx <= 32'h00000000;
    end else begin
      cap_eax <= CAP_EAX;
      cap_ebx <= CAP_EBX;
    end
  end

endmodule // ecb_top
`default_nettype wire

// [verification/ecb_top_monitor.sv]
// port checker for the event counter bank, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module ecb_top_monitor #(
  parameter NUM_LP = 2,
  parameter NUM_CTR = 2,
  parameter CTR_W = 40,
  parameter NUM_EV = 7
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register access
  input wire logic msr_req,
  input wire logic [7:0] msr_lp,
  input wire logic [31:0] msr_addr,
  input wire logic msr_ack,
  input wire logic msr_fault,
  input wire logic [63:0] msr_rdata,
  // capability, pins, interrupts
  input wire logic [31:0] cap_eax,
  input wire logic [31:0] cap_ebx,
  input wire logic [NUM_LP*NUM_CTR-1:0] monitor_output_pin,
  input wire logic [NUM_LP-1:0] irq_req
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  chk_ack_follows_req: assert property (msr_req |=> msr_ack)
    else $error("request not answered next cycle");
  chk_ack_has_cause: assert property (msr_ack |-> $past(msr_req))
    else $error("answer without a request");
  chk_lp_refused: assert property (msr_req && msr_lp >= NUM_LP |=> msr_fault)
    else $error("access to a missing logical processor not refused");
  chk_block_end: assert property (msr_req && (msr_addr == 32'hC1 + NUM_CTR || msr_addr == 32'h186 + NUM_CTR) |=> msr_fault)
    else $error("address past a register block not refused");
  chk_ctr_mapped: assert property (msr_req && msr_lp < NUM_LP && msr_addr >= 32'hC1 && msr_addr < 32'hC1 + NUM_CTR
    |=> msr_ack && !msr_fault)
    else $error("counter address refused");
  chk_cap_fields: assert property (!$past(rst) |-> cap_eax[31:8] == {8'(NUM_EV), 8'(CTR_W), 8'(NUM_CTR)} && cap_eax[7:0] != 8'h0)
    else $error("capability fields wrong");
  chk_cap_events: assert property (!$past(rst) |-> cap_ebx[NUM_EV-1:0] == {NUM_EV{1'b1}})
    else $error("supported event vector wrong");
  chk_pin_width: assert property ($rose(monitor_output_pin[0]) |-> monitor_output_pin[0][*4])
    else $error("pin pulse shorter than one bus clock");
  chk_irq_with_pin: assert property (irq_req[0] |-> |monitor_output_pin[NUM_CTR-1:0])
    else $error("overflow interrupt without pin toggle");
endmodule // ecb_top_monitor
bind ecb_top ecb_top_monitor #(.NUM_LP(NUM_LP), .NUM_CTR(NUM_CTR), .CTR_W(CTR_W), .NUM_EV(NUM_EV)) ecb_top_monitor_i (
  .clk(clk), .rst(rst), .msr_req(msr_req), .msr_lp(msr_lp), .msr_addr(msr_addr), .msr_ack(msr_ack),
  .msr_fault(msr_fault), .msr_rdata(msr_rdata), .cap_eax(cap_eax), .cap_ebx(cap_ebx),
  .monitor_output_pin(monitor_output_pin), .irq_req(irq_req));
`default_nettype wire

// [verification/tb_ecb_top.sv]
// self-checking bench for the event counter bank
`timescale 1ns/1ps
`default_nettype none
module tb_ecb_top;
  logic clk = 0;
  logic rst = 1;
  logic msr_req = 0;
  logic msr_wr = 0;
  logic [7:0] msr_lp = 8'h0;
  logic [31:0] msr_addr = 32'h0;
  logic [63:0] msr_wdata = 64'h0;
  logic msr_ack, msr_fault;
  logic [63:0] msr_rdata;
  logic [31:0] cap_eax, cap_ebx;
  logic [55:0] ev_count = 56'h0;
  logic [3:0] cpl = 4'h0;
  logic [3:0] monitor_output_pin;
  logic [1:0] irq_req;
  logic [5:0] outs;
  logic [31:0] seed = 32'h6E738D11;
  logic [31:0] exp_cnt;
  logic prev;
  logic [64:0] exp_q[$];
  int mismatches = 0;
  int cmp_count = 0;
  // plain, supervisor, qualifier miss, threshold, inverted threshold (user only: idle cpl 0 keeps it quiet), edge, off
  logic [31:0] sels[7] = '{32'h00410001, 32'h00420002, 32'h00430103, 32'h02430004,
    32'h02C10005, 32'h00470006, 32'h00030001};
  assign outs = {irq_req, monitor_output_pin};
  always #2.5 clk = ~clk;
  // 32-bit counters so a plain counter write can reach the wrap point
  ecb_top #(.CTR_W(32)) ecb_top_i (.clk(clk), .rst(rst), .msr_req(msr_req), .msr_wr(msr_wr), .msr_lp(msr_lp),
    .msr_addr(msr_addr), .msr_wdata(msr_wdata), .msr_ack(msr_ack), .msr_fault(msr_fault), .msr_rdata(msr_rdata),
    .cap_eax(cap_eax), .cap_ebx(cap_ebx), .ev_count(ev_count), .cpl(cpl), .monitor_output_pin(monitor_output_pin),
    .irq_req(irq_req));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [64:0] got, input logic [64:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic acc(input logic wr, input logic [7:0] lp, input logic [31:0] a, input logic [63:0] d,
    input logic [64:0] e);
    @(posedge clk);
    #1;
    {msr_req, msr_wr, msr_lp, msr_addr, msr_wdata} = {1'b1, wr, lp, a, d};
    exp_q.push_back(e);
    @(posedge clk);
    #1;
    msr_req = 0;
  endtask
  always @(negedge clk) if (!rst && msr_ack) begin
    if (exp_q.size() == 0) chk(65'h1, 65'h0);
    else chk({msr_fault, msr_rdata}, exp_q.pop_front());
  end
  task automatic events(input logic [31:0] s, input int n);
    logic [3:0] c;
    logic pr, q, cond;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      #1;
      ev_count = 56'({rnd(), rnd()});
      cpl = 4'(rnd());
      c = (s[7:0] != 8'h0 && s[7:0] < 8'h8 && s[15:8] == 8'h0) ? ev_count[(int'(s[2:0]) - 1) * 4 +: 4] : 4'h0;
      pr = (s[16] && cpl[1:0] != 2'h0) || (s[17] && cpl[1:0] == 2'h0);
      q = (s[31:24] == 8'h0) ? c != 4'h0 : (c >= s[31:24]) ^ s[23];
      cond = pr && q;
      if (s[22] && s[18]) exp_cnt += 32'(cond && !prev);
      else if (s[22] && pr) exp_cnt += (s[31:24] == 8'h0) ? 32'(c) : 32'(q);
      prev = cond && s[22];
    end
    @(posedge clk);
    #1;
    {ev_count, cpl} = 60'h0;
  endtask
  task automatic pulse_seen(input int b);
    logic hit;
    hit = 0;
    repeat (4) begin
      @(negedge clk);
      hit = hit | outs[b];
    end
    chk(65'(hit), 65'h1);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst = 0;
    acc(1, 0, 32'h187, 64'hFFFFFFFFFFFFFFFF, 0);
    chk(65'({cap_ebx, cap_eax}), 65'h7F07200201);
    acc(0, 0, 32'h187, 0, 65'hFFDFFFFF);
    acc(1, 0, 32'h187, 0, 0);
    acc(1, 1, 32'hC1, 64'hFFFFFFFF12345678, 0);
    acc(0, 1, 32'hC1, 0, 65'h12345678);
    acc(0, 0, 32'hC3, 0, {1'b1, 64'h0});
    acc(0, 2, 32'hC1, 0, {1'b1, 64'h0});
    $display("register test done");
    for (int k = 0; k < 7; k++) begin
      acc(1, 0, 32'h186, 0, 0);
      acc(1, 0, 32'hC1, 0, 0);
      acc(1, 0, 32'h186, 64'(sels[k]), 0);
      exp_cnt = 0;
      prev = 0;
      events(sels[k], 40);
      acc(1, 0, 32'h186, 0, 0);
      acc(0, 0, 32'hC1, 0, {33'h0, exp_cnt});
    end
    acc(0, 1, 32'hC1, 0, 65'h12345678);
    $display("counting test done");
    acc(1, 0, 32'hC1, 64'hFFFFFFFE, 0);
    acc(1, 0, 32'h186, 64'h00530001, 0);
    @(posedge clk);
    #1;
    ev_count = 56'h3;
    @(posedge clk);
    #1;
    ev_count = 56'h0;
    pulse_seen(4);
    acc(0, 0, 32'hC1, 0, 65'h1);
    acc(1, 0, 32'h186, 64'h005B0001, 0);
    repeat (4) @(posedge clk);
    #1;
    ev_count = 56'h1;
    @(posedge clk);
    #1;
    ev_count = 56'h0;
    pulse_seen(0);
    $display("overflow and pin test done");
    repeat (3) @(posedge clk);
    chk(65'(exp_q.size()), 65'h0);
    report_and_stop();
  end
endmodule // tb_ecb_top
`default_nettype wire
